// File: src/rswd_pkg.sv
// Shared constants, types and helpers for the receiver select word decoder
package rswd_pkg;
   // Word layout
   localparam int          RSWD_WORD_W     = 12;
   localparam int          RSWD_IR_BIT     = 11;
   localparam int          RSWD_CODE_MSB   = 10;
   localparam int          RSWD_CODE_LSB   = 6;
   localparam int          RSWD_LVL_MSB    = 7;
   localparam int          RSWD_LVL_LSB    = 6;
   localparam int          RSWD_BCD_W      = 6;
   localparam int          RSWD_MODE_BITS  = 5;
   localparam int          RSWD_LVL_W      = 2;
   // Channel organisation
   localparam int          RSWD_CH_COUNT   = 20;
   localparam int          RSWD_PAIR_COUNT = 10;
   localparam int          RSWD_LOOP_CH    = 19;
   // Code points (octal 23, 24, 25)
   localparam logic [4:0]  RSWD_CODE_MAX   = 5'h13;
   localparam logic [4:0]  RSWD_CODE_LOOP  = 5'h13;
   localparam logic [4:0]  RSWD_CODE_GRP1  = 5'h14;
   localparam logic [4:0]  RSWD_CODE_GRP2  = 5'h15;
   localparam logic [5:0]  RSWD_BCD_MAX    = 6'h31;
   // Reset values
   localparam logic [5:0]  RSWD_SEL_RST    = 6'h00;
   localparam logic        RSWD_MODE_RST   = 1'b0;
   // Controller registers on APB
   localparam int          RSWD_ADDR_W     = 12;
   localparam logic [11:0] RSWD_OFF_CMD    = 12'h000;
   localparam logic [11:0] RSWD_OFF_STAT   = 12'h004;
   localparam logic [11:0] RSWD_OFF_RESP   = 12'h008;
   localparam int          RSWD_STAT_BUSY  = 0;
   localparam int          RSWD_STAT_AVAIL = 1;

   typedef logic [RSWD_WORD_W-1:0] rswd_word_type;
   typedef logic [RSWD_BCD_W-1:0]  rswd_bcd_type;

   // Legal receiver number: BCD 01 to 31
   function automatic logic rswd_bcd_ok(input rswd_bcd_type v);
      rswd_bcd_ok = (v[3:0] <= 4'h9) && (v != 6'h00) && (v <= RSWD_BCD_MAX);
   endfunction : rswd_bcd_ok

   // Mode bit b of a group word to pair index (pair number minus one)
   function automatic logic [3:0] rswd_pair_idx(input logic grp2, input logic [2:0] b);
      if (b == 3'h4)
         rswd_pair_idx = grp2 ? 4'h9 : 4'h8;
      else
         rswd_pair_idx = grp2 ? (4'h4 + {2'h0, b[1:0]}) : {2'h0, b[1:0]};
   endfunction : rswd_pair_idx
endpackage : rswd_pkg

// File: src/rswd_link_if.sv
// Word multiplexer link between the computer end and the decoder end
`timescale 1ns/10ps
interface rswd_link_if;
   import rswd_pkg::*;
   // Output word multiplexer: computer to decoder
   logic          cmd_valid;
   rswd_word_type cmd_word;
   logic          cmd_ack;
   // Input word multiplexer: decoder to computer
   logic          sts_valid;
   rswd_word_type sts_word;
   logic          sts_ack;

   modport dev
   (
      input  cmd_valid,
      input  cmd_word,
      output cmd_ack,
      output sts_valid,
      output sts_word,
      input  sts_ack
   );
   modport host
   (
      output cmd_valid,
      output cmd_word,
      input  cmd_ack,
      input  sts_valid,
      input  sts_word,
      output sts_ack
   );
endinterface : rswd_link_if

// File: src/rswd_dev.sv
// Decoder end: command decode, selection storage, mode control and status words
`timescale 1ns/10ps
module rswd_dev
#(
   parameter int CHANNELS = 20
)
(
   // Clock and reset
   input  wire logic                                                     clk_in,
   input  wire logic                                                     rst_n_in,
   // Computer side
   rswd_link_if.dev                                                      link,
   // Receiver group inputs
   input  wire logic [rswd_pkg::RSWD_PAIR_COUNT-1:0]                     forced_manual_n_in,
   input  wire logic [rswd_pkg::RSWD_CH_COUNT-1:0][rswd_pkg::RSWD_BCD_W-1:0] manual_sel_in,
   input  wire logic [rswd_pkg::RSWD_LVL_W-1:0]                          carrier_level_in,
   input  wire logic                                                     level_valid_in,
   // Receiver group outputs
   output logic      [rswd_pkg::RSWD_CH_COUNT-1:0][rswd_pkg::RSWD_BCD_W-1:0] sel_code_out,
   output logic      [rswd_pkg::RSWD_PAIR_COUNT-1:0]                     manual_mode_out,
   output logic                                                          rf_request_out
);
   import rswd_pkg::*;

   // Code space fixes the channel count
   if (CHANNELS != RSWD_CH_COUNT)
   begin : g_bad_channels
      $error("rswd_dev: CHANNELS must be 20");
   end

   typedef struct packed {
      logic [RSWD_CH_COUNT-1:0][RSWD_BCD_W-1:0] sel;
      logic [RSWD_PAIR_COUNT-1:0]               mode;
      logic [RSWD_PAIR_COUNT-1:0]               frc_s1;
      logic [RSWD_PAIR_COUNT-1:0]               frc_s2;
      logic [RSWD_CH_COUNT-1:0][RSWD_BCD_W-1:0] man_s1;
      logic [RSWD_CH_COUNT-1:0][RSWD_BCD_W-1:0] man_s2;
      logic [RSWD_LVL_W:0]                      lvl_s1;
      logic [RSWD_LVL_W:0]                      lvl_s2;
      logic                                     vld_s3;
      logic                                     lvl_pend;
      logic [RSWD_LVL_W-1:0]                    lvl_data;
      logic                                     cmd_ack;
      logic                                     sts_valid;
      rswd_word_type                            sts_word;
      logic                                     rf_req;
      logic [RSWD_CH_COUNT-1:0][RSWD_BCD_W-1:0] drv_sel;
      logic [RSWD_PAIR_COUNT-1:0]               drv_mode;
   } rswd_dev_state_type;

   rswd_dev_state_type q;
   rswd_dev_state_type d;

   logic [RSWD_PAIR_COUNT-1:0]               forced;
   logic [RSWD_PAIR_COUNT-1:0]               inhibit;
   logic [RSWD_CH_COUNT-1:0][RSWD_BCD_W-1:0] applied;
   logic [RSWD_MODE_BITS-1:0]                grp_mode;
   logic                                     ir;
   logic [4:0]                               code;
   rswd_bcd_type                             rcv;
   logic                                     is_grp;
   logic                                     grp2;
   logic                                     rise;
   logic                                     load_lvl;
   logic                                     take;

   always_comb
   begin
      d        = q;
      forced   = '0;
      inhibit  = '0;
      applied  = '0;
      grp_mode = '0;
      // Two-stage synchronisers for all receiver group pins
      d.frc_s1 = forced_manual_n_in;
      d.frc_s2 = q.frc_s1;
      d.man_s1 = manual_sel_in;
      d.man_s2 = q.man_s1;
      d.lvl_s1 = {level_valid_in, carrier_level_in};
      d.lvl_s2 = q.lvl_s1;
      d.vld_s3 = q.lvl_s2[RSWD_LVL_W];
      d.cmd_ack = 1'b0;
      d.rf_req  = 1'b0;

      // Per pair: forced manual line is low when active
      for (int p = 0; p < RSWD_PAIR_COUNT; p++)
      begin
         forced[p]  = ~q.frc_s2[p];
         inhibit[p] = q.mode[p] | forced[p];
      end
      // Applied receiver as seen by the receiver: manual selectors when inhibited
      for (int c = 0; c < RSWD_CH_COUNT; c++)
      begin
         applied[c] = inhibit[c/2] ? q.man_s2[c] : q.sel[c];
      end

      ir     = link.cmd_word[RSWD_IR_BIT];
      code   = link.cmd_word[RSWD_CODE_MSB:RSWD_CODE_LSB];
      rcv    = link.cmd_word[RSWD_BCD_W-1:0];
      is_grp = (code == RSWD_CODE_GRP1) || (code == RSWD_CODE_GRP2);
      grp2   = (code == RSWD_CODE_GRP2);
      for (int b = 0; b < RSWD_MODE_BITS; b++)
      begin
         grp_mode[b] = inhibit[rswd_pair_idx(grp2, 3'(b))];
      end

      // Level valid edge; a new event is never lost to the clear
      rise     = q.lvl_s2[RSWD_LVL_W] & ~q.vld_s3;
      load_lvl = ~q.sts_valid & q.lvl_pend;
      d.lvl_pend = rise | (q.lvl_pend & ~load_lvl);
      if (rise)
      begin
         d.lvl_data = q.lvl_s2[RSWD_LVL_W-1:0];
      end

      // Status slot release on the multiplexer acknowledge
      if (q.sts_valid && link.sts_ack)
      begin
         d.sts_valid = 1'b0;
      end

      // Status requests wait while a status word or a level report is pending
      take = link.cmd_valid & ~q.cmd_ack & (~ir | (~q.sts_valid & ~q.lvl_pend));

      if (load_lvl)
      begin
         d.sts_valid = 1'b1;
         d.sts_word  = {1'b1, 3'h0, q.lvl_data, q.sel[RSWD_LOOP_CH]};
      end

      if (take)
      begin
         d.cmd_ack = 1'b1;
         if (!ir && (code <= RSWD_CODE_MAX) && rswd_bcd_ok(rcv))
         begin
            d.sel[code] = rcv;
            if (code == RSWD_CODE_LOOP)
            begin
               d.rf_req = 1'b1;
            end
         end
         else if (!ir && is_grp)
         begin
            for (int b = 0; b < RSWD_MODE_BITS; b++)
            begin
               d.mode[rswd_pair_idx(grp2, 3'(b))] = link.cmd_word[b];
            end
         end
         else if (ir && (code <= RSWD_CODE_MAX))
         begin
            d.sts_valid = 1'b1;
            d.sts_word  = {1'b0, code, applied[code]};
         end
         else if (ir && is_grp)
         begin
            d.sts_valid = 1'b1;
            d.sts_word  = {1'b0, code, 1'b0, grp_mode};
         end
         // Anything else is acknowledged and dropped
      end

      // Drive lines; inhibited pairs leave the lines to the manual selectors
      for (int c = 0; c < RSWD_CH_COUNT; c++)
      begin
         d.drv_sel[c] = inhibit[c/2] ? RSWD_SEL_RST : d.sel[c];
      end
      d.drv_mode = q.mode & ~forced;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         q          <= '0;
         q.sel      <= {RSWD_CH_COUNT{RSWD_SEL_RST}};
         q.mode     <= {RSWD_PAIR_COUNT{RSWD_MODE_RST}};
         q.frc_s1   <= '1;
         q.frc_s2   <= '1;
      end
      else
      begin
         q <= d;
      end
   end

   assign link.cmd_ack   = q.cmd_ack;
   assign link.sts_valid = q.sts_valid;
   assign link.sts_word  = q.sts_word;
   assign sel_code_out    = q.drv_sel;
   assign manual_mode_out = q.drv_mode;
   assign rf_request_out  = q.rf_req;
endmodule : rswd_dev

// File: src/rswd_host.sv
// Computer end: APB register front end driving the word multiplexer link
`timescale 1ns/10ps
module rswd_host
(
   // Clock and reset
   input  wire logic                              clk_in,
   input  wire logic                              rst_n_in,
   // APB slave
   input  wire logic                              psel_in,
   input  wire logic                              penable_in,
   input  wire logic                              pwrite_in,
   input  wire logic [rswd_pkg::RSWD_ADDR_W-1:0]  paddr_in,
   input  wire logic [31:0]                       pwdata_in,
   output logic      [31:0]                       prdata_out,
   output logic                                   pready_out,
   output logic                                   pslverr_out,
   // Decoder side
   rswd_link_if.host                              link
);
   import rswd_pkg::*;

   typedef struct packed {
      logic          cmd_valid;
      rswd_word_type cmd_word;
      logic          sts_ack;
      rswd_word_type resp_word;
      logic          resp_avail;
      logic          pready;
      logic          pslverr;
      logic [31:0]   prdata;
   } rswd_host_state_type;

   rswd_host_state_type q;
   rswd_host_state_type d;

   logic setup;
   logic done;
   logic take;
   logic clr;

   always_comb
   begin
      d         = q;
      d.sts_ack = 1'b0;
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      setup = psel_in & ~penable_in & ~q.pready;
      done  = psel_in & penable_in & q.pready;

      // Answer is prepared in the setup cycle so pready comes from a flop
      if (setup)
      begin
         d.pready = 1'b1;
         d.prdata = '0;
         if (paddr_in == RSWD_OFF_CMD)
         begin
            // A command write while one is still in flight is refused
            d.pslverr = pwrite_in & q.cmd_valid;
         end
         else if (paddr_in == RSWD_OFF_STAT)
         begin
            d.prdata[RSWD_STAT_BUSY]  = q.cmd_valid;
            d.prdata[RSWD_STAT_AVAIL] = q.resp_avail;
         end
         else if (paddr_in == RSWD_OFF_RESP)
         begin
            d.prdata[RSWD_WORD_W-1:0] = q.resp_word;
         end
         else
         begin
            d.pslverr = 1'b1;
         end
      end

      // Command word held on the link until acknowledged
      if (q.cmd_valid && link.cmd_ack)
      begin
         d.cmd_valid = 1'b0;
      end
      if (done && pwrite_in && !q.pslverr && paddr_in == RSWD_OFF_CMD)
      begin
         d.cmd_valid = 1'b1;
         d.cmd_word  = pwdata_in[RSWD_WORD_W-1:0];
      end

      // Status words accepted only into a free holding register
      take = link.sts_valid & ~q.sts_ack & ~q.resp_avail;
      clr  = done & ~pwrite_in & (paddr_in == RSWD_OFF_RESP);
      if (take)
      begin
         d.sts_ack   = 1'b1;
         d.resp_word = link.sts_word;
      end
      d.resp_avail = take | (q.resp_avail & ~clr);
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign prdata_out     = q.prdata;
   assign pready_out     = q.pready;
   assign pslverr_out    = q.pslverr;
   assign link.cmd_valid = q.cmd_valid;
   assign link.cmd_word  = q.cmd_word;
   assign link.sts_ack   = q.sts_ack;
endmodule : rswd_host

// File: tb/rswd_asserts.sv
// Link handshake and status word layout assertions
`timescale 1ns/10ps
module rswd_asserts
(
   // Clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_n_in,
   // Command path
   input  wire logic                   cmd_valid,
   input  wire rswd_pkg::rswd_word_type cmd_word,
   input  wire logic                   cmd_ack,
   // Status path
   input  wire logic                   sts_valid,
   input  wire rswd_pkg::rswd_word_type sts_word,
   input  wire logic                   sts_ack
);
   import rswd_pkg::*;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // A legal status request taken by the decoder
   sequence req_taken;
      cmd_valid && cmd_ack && cmd_word[11] && (cmd_word[10:6] <= RSWD_CODE_GRP2);
   endsequence
   sequence ack_pulse(v, a);
      v && a ##1 !a;
   endsequence
   // Bounds assume the bench drains the response register promptly
   cmd_ack_pulse_a: assert property (cmd_ack |-> ack_pulse(cmd_valid, cmd_ack)) else $error("cmd ack bad");
   cmd_answer_a: assert property ($rose(cmd_valid) |-> ##[1:200] cmd_ack) else $error("cmd not acked");
   cmd_hold_a: assert property (cmd_valid && !cmd_ack |=> cmd_valid && $stable(cmd_word))
      else $error("cmd dropped");
   sts_hold_a: assert property (sts_valid && !sts_ack |=> sts_valid && $stable(sts_word))
      else $error("sts dropped");
   sts_ack_pulse_a: assert property (sts_ack |-> ack_pulse(sts_valid, sts_ack)) else $error("sts ack bad");
   sts_answer_a: assert property ($rose(sts_valid) |-> ##[1:400] sts_ack) else $error("sts not taken");
   req_answer_a: assert property (req_taken |-> sts_valid && !sts_word[11] && (sts_word[10:6] == cmd_word[10:6]))
      else $error("request unanswered");
   level_spare_a: assert property (sts_valid && sts_word[11] |-> sts_word[10:8] == 3'h0)
      else $error("spare set");
   proc_code_a: assert property (sts_valid && !sts_word[11] |-> sts_word[10:6] <= RSWD_CODE_GRP2)
      else $error("bad code");
   mode_spare_a: assert property (sts_valid && !sts_word[11] && (sts_word[10:6] >= RSWD_CODE_GRP1) |-> !sts_word[5])
      else $error("mode spare set");
endmodule : rswd_asserts

// File: tb/receiver_select_word_decoder_tb.sv
// Bench joining the computer end and the decoder end over the word link
`timescale 1ns/10ps
module receiver_select_word_decoder_tb;
   import rswd_pkg::*;
   logic                                     clk_in, rst_n_in, psel, penable, pwrite, pready, sl, pslverr;
   logic                                     rf_req, lvl_valid;
   logic [11:0]                              paddr;
   logic [31:0]                              pwdata, prdata, rd;
   logic [RSWD_PAIR_COUNT-1:0]               forced_manual_n, manual_mode;
   logic [RSWD_CH_COUNT-1:0][RSWD_BCD_W-1:0] manual_sel, sel_code;
   logic [1:0]                               carrier_level;
   int                                       errors, total_checks, rf_cnt, n0;

   rswd_link_if rswd_link_if_inst ();
   rswd_host rswd_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .link(rswd_link_if_inst));
   rswd_dev #(.CHANNELS(20)) rswd_dev_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(rswd_link_if_inst),
      .forced_manual_n_in(forced_manual_n), .manual_sel_in(manual_sel), .carrier_level_in(carrier_level),
      .level_valid_in(lvl_valid), .sel_code_out(sel_code), .manual_mode_out(manual_mode), .rf_request_out(rf_req));
   rswd_asserts rswd_asserts_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid(rswd_link_if_inst.cmd_valid),
      .cmd_word(rswd_link_if_inst.cmd_word), .cmd_ack(rswd_link_if_inst.cmd_ack),
      .sts_valid(rswd_link_if_inst.sts_valid), .sts_word(rswd_link_if_inst.sts_word),
      .sts_ack(rswd_link_if_inst.sts_ack));

   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // Pulses are one cycle wide, so count them at every edge
   always @(posedge clk_in)
      if (rf_req === 1'b1)
         rf_cnt++;

   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Idle edge first, so no signal is assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do
      begin
         @(posedge clk_in);
      end
      while (pready !== 1'b1);
      rd = prdata;
      sl = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cmd(input logic [11:0] w);
      apb(1'b1, RSWD_OFF_CMD, {20'h0, w});
      do
      begin
         apb(1'b0, RSWD_OFF_STAT, 32'h0);
      end
      while (rd[RSWD_STAT_BUSY] !== 1'b0);
   endtask : cmd

   task automatic resp();
      do
      begin
         apb(1'b0, RSWD_OFF_STAT, 32'h0);
      end
      while (rd[RSWD_STAT_AVAIL] !== 1'b1);
      apb(1'b0, RSWD_OFF_RESP, 32'h0);
   endtask : resp

   task automatic t_select();
      logic [11:0] bad [3] = '{12'h00a, 12'h032, 12'h585};
      cmd({1'b0, 5'h00, 6'h07});
      cmd({1'b0, 5'h01, 6'h10});
      chk(rf_cnt, 0);
      cmd({1'b0, 5'h13, 6'h31});
      chk(rf_cnt, 1);
      chk(sel_code[0], 6'h07);
      chk(sel_code[1], 6'h10);
      chk(sel_code[19], 6'h31);
      // Bad BCD, over-range BCD, and an unused code with select layout
      foreach (bad[i])
         cmd(bad[i]);
      chk({sel_code[0], sel_code[19], manual_mode}, {6'h07, 6'h31, 10'h000});
      $display("select test done");
   endtask : t_select

   task automatic t_status();
      cmd({1'b1, 5'h13, 6'h00});
      resp();
      chk(rd, {20'h0, 1'b0, 5'h13, 6'h31});
      cmd({1'b1, 5'h14, 6'h00});
      resp();
      chk(rd, {20'h0, 1'b0, 5'h14, 6'h00});
      $display("status test done");
   endtask : t_status

   task automatic t_mode();
      cmd({1'b0, 5'h14, 1'b0, 5'b10001});
      chk(manual_mode, 10'h101);
      chk({sel_code[1], sel_code[0]}, 12'h000);
      cmd({1'b1, 5'h00, 6'h00});
      resp();
      chk(rd, {20'h0, 12'h025});
      cmd({1'b0, 5'h15, 1'b0, 5'b10010});
      chk(manual_mode, 10'h321);
      chk(sel_code[19], 6'h00);
      cmd({1'b1, 5'h15, 6'h00});
      resp();
      chk(rd, {20'h0, 1'b0, 5'h15, 1'b0, 5'b10010});
      cmd({1'b0, 5'h15, 6'h00});
      chk(sel_code[19], 6'h31);
      $display("mode test done");
   endtask : t_mode

   task automatic t_forced();
      forced_manual_n <= 10'h3fd;
      // Two-stage synchroniser in front of the forced line
      repeat (4) @(posedge clk_in);
      cmd({1'b0, 5'h02, 6'h12});
      chk(sel_code[2], 6'h00);
      cmd({1'b1, 5'h14, 6'h00});
      resp();
      chk(rd, {20'h0, 1'b0, 5'h14, 1'b0, 5'b10011});
      forced_manual_n <= 10'h3ff;
      repeat (4) @(posedge clk_in);
      chk(sel_code[2], 6'h12);
      $display("forced test done");
   endtask : t_forced

   task automatic t_level();
      carrier_level <= 2'h2;
      lvl_valid     <= 1'b1;
      repeat (6) @(posedge clk_in);
      lvl_valid     <= 1'b0;
      resp();
      chk(rd, {20'h0, 1'b1, 3'h0, 2'h2, 6'h31});
      // Unmapped address must be refused with no data
      apb(1'b0, 12'h00c, 32'h0);
      chk({31'h0, sl}, 32'h1);
      chk(rd, 32'h0);
      $display("level test done");
   endtask : t_level

   initial
   begin
      rst_n_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      forced_manual_n = 10'h3ff;
      manual_sel = {RSWD_CH_COUNT{6'h25}};
      carrier_level = 2'h0;
      lvl_valid = 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_select();
      t_status();
      t_mode();
      t_forced();
      t_level();
      give_verdict();
   end

   // Whole run needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge clk_in);
      errors++;
      give_verdict();
   end
endmodule : receiver_select_word_decoder_tb
